//--- pkg/bst_params.svh
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
// Instruction codes
`define BST_IR_W        3
`define BST_IR_EXTEST   3'h0
`define BST_IR_SAMPLE   3'h1
`define BST_IR_HIGHZ    3'h5
`define BST_IR_CLAMP    3'h6
`define BST_IR_BYPASS   3'h7
// Capture pattern for the instruction register
`define BST_IR_CAPTURE  3'h1
// Cells per pin and cell order within a pin
`define BST_CELLS_PER_IO 3
`define BST_CELL_IN     0
`define BST_CELL_OUT    1
`define BST_CELL_OE     2
// Test clock limit, MHz
`define BST_TCK_MAX_MHZ 20
// Synchroniser depth for the system domain
`define BST_SYNC_STAGES 3
`endif

//--- pkg/bst_pkg.sv
package bst_pkg;
	// Tap controller states, Gray-coded along the scan paths
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SDS = 4'h3, CDR = 4'h2,
		SDR = 4'h6, E1D = 4'h7, PDR = 4'h5, E2D = 4'h4,
		UDR = 4'hc, SIS = 4'hd, CIR = 4'hf, SIR = 4'he,
		E1I = 4'ha, PIR = 4'hb, E2I = 4'h9, UIR = 4'h8
	} bst_state_t;
	typedef enum logic [1:0] {MODE_FUNC = 2'h0, MODE_DRIVE = 2'h1, MODE_HIGHZ = 2'h2} bst_mode_t;
endpackage

//--- pkg/bst_fifo_if.sv
`timescale 1ns/1ps
interface bst_fifo_if #(parameter int W = 8) ();
	logic         inValid;
	logic         inReady;
	logic [W-1:0] inData;
	logic         outValid;
	logic         outReady;
	logic [W-1:0] outData;
	modport fill (output inValid, output inData, input inReady);
	modport drain (input outValid, input outData, output outReady);
	modport fifo (input inValid, input inData, output inReady, output outValid, output outData, input outReady);
endinterface

//--- rtl/bst_fifo.sv
`timescale 1ns/1ps
// Dual-clock FIFO, gray pointers, registered read data
module bst_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic wClk,
	input  wire logic rClk,
	input  wire logic rst,
	bst_fifo_if.fifo  port
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wBin_r, wGray_r, rBin_r, rGray_r;
	logic [AW:0]  wqG1_r, wqG2_r, rqG1_r, rqG2_r;
	logic [W-1:0] rData_r;
	logic         rValid_r;
	wire  [AW:0]  wBinNxt = wBin_r + (AW+1)'(1);
	wire  [AW:0]  rBinNxt = rBin_r + (AW+1)'(1);
	wire          full    = wGray_r == {~rqG2_r[AW:AW-1], rqG2_r[AW-2:0]};
	wire          empty   = rGray_r == wqG2_r;
	wire          doWr    = port.inValid && !full;
	wire          doRd    = !empty && (!rValid_r || port.outReady);
	assign port.inReady  = !full;
	assign port.outValid = rValid_r;
	assign port.outData  = rData_r;
	// Write side
	always_ff @(posedge wClk or posedge rst) begin
		if (rst) begin
			wBin_r  <= '0;
			wGray_r <= '0;
			rqG1_r  <= '0;
			rqG2_r  <= '0;
		end else begin
			rqG1_r <= rGray_r;
			rqG2_r <= rqG1_r;
			if (doWr) begin
				wBin_r  <= wBinNxt;
				wGray_r <= wBinNxt ^ (wBinNxt >> 1);
			end
		end
	end
	always_ff @(posedge wClk) begin
		if (doWr)
			mem[wBin_r[AW-1:0]] <= port.inData;
	end
	// Read side, data held in an output register
	always_ff @(posedge rClk or posedge rst) begin
		if (rst) begin
			rBin_r   <= '0;
			rGray_r  <= '0;
			wqG1_r   <= '0;
			wqG2_r   <= '0;
			rValid_r <= 1'b0;
			rData_r  <= '0;
		end else begin
			wqG1_r <= wGray_r;
			wqG2_r <= wqG1_r;
			if (doRd) begin
				rData_r  <= mem[rBin_r[AW-1:0]];
				rBin_r   <= rBinNxt;
				rGray_r  <= rBinNxt ^ (rBinNxt >> 1);
				rValid_r <= 1'b1;
			end else if (port.outReady) begin
				rValid_r <= 1'b0;
			end
		end
	end
endmodule

//--- rtl/bst_tap.sv
`timescale 1ns/1ps
`include "bst_params.svh"
module bst_tap
	import bst_pkg::*;
#(
	parameter int NIO = 4
) (
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic           tck,
	input  wire logic           tms,
	input  wire logic           tdi,
	output logic                tdo,
	output logic                tdoOe,
	input  wire logic [NIO-1:0] coreOut,
	input  wire logic [NIO-1:0] coreOe,
	output logic      [NIO-1:0] coreIn,
	input  wire logic [NIO-1:0] padIn,
	output logic      [NIO-1:0] padOut,
	output logic      [NIO-1:0] padOe,
	output logic      [2:0]     instr,
	output logic                testActive,
	output logic                capValid,
	output logic [`BST_CELLS_PER_IO*NIO-1:0] capData,
	input  wire logic           capReady
);
	import bst_pkg::*;
	localparam int CN = `BST_CELLS_PER_IO * NIO;

	bst_state_t      st_r, st_nxt;
	logic [2:0]      irSh_r, ir_r;
	logic [CN-1:0]   bsSh_r, bsUpd_r;
	logic            byp_r, tdoNeg_r, oeNeg_r;
	logic [2:0]      tms5_r;

	// Decoding of the held instruction
	wire isExtest  = ir_r == `BST_IR_EXTEST;
	wire isSample  = ir_r == `BST_IR_SAMPLE;
	wire isHighz   = ir_r == `BST_IR_HIGHZ;
	wire isClamp   = ir_r == `BST_IR_CLAMP;
	wire isBypass  = !(isExtest || isSample || isHighz || isClamp);
	wire bsSel     = isExtest || isSample;
	bst_mode_t mode;
	assign mode = (isExtest || isClamp) ? MODE_DRIVE : (isHighz ? MODE_HIGHZ : MODE_FUNC);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			TLR: st_nxt = tms ? TLR : RTI;
			RTI: st_nxt = tms ? SDS : RTI;
			SDS: st_nxt = tms ? SIS : CDR;
			CDR: st_nxt = tms ? E1D : SDR;
			SDR: st_nxt = tms ? E1D : SDR;
			E1D: st_nxt = tms ? UDR : PDR;
			PDR: st_nxt = tms ? E2D : PDR;
			E2D: st_nxt = tms ? UDR : SDR;
			UDR: st_nxt = tms ? SDS : RTI;
			SIS: st_nxt = tms ? TLR : CIR;
			CIR: st_nxt = tms ? E1I : SIR;
			SIR: st_nxt = tms ? E1I : SIR;
			E1I: st_nxt = tms ? UIR : PIR;
			PIR: st_nxt = tms ? E2I : PIR;
			E2I: st_nxt = tms ? UIR : SIR;
			UIR: st_nxt = tms ? SDS : RTI;
			default: st_nxt = TLR;
		endcase
	end

	// mode select sampled on rising test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			st_r   <= TLR;
			tms5_r <= 3'h0;
		end else begin
			st_r   <= st_nxt;
			tms5_r <= tms ? ((tms5_r == 3'h5) ? 3'h5 : tms5_r + 3'h1) : 3'h0;
		end
	end

	// Boundary cell parallel inputs: pin in, core out, core enable per pin
	logic [CN-1:0] parIn;
	logic [NIO-1:0] updOut;
	genvar g;
	generate
		for (g = 0; g < NIO; g++) begin : g_cell
			assign parIn[`BST_CELLS_PER_IO*g+`BST_CELL_IN]  = padIn[g];
			assign parIn[`BST_CELLS_PER_IO*g+`BST_CELL_OUT] = coreOut[g];
			assign parIn[`BST_CELLS_PER_IO*g+`BST_CELL_OE]  = coreOe[g];
			// output cells seen by clamp check
			assign updOut[g] = bsUpd_r[`BST_CELLS_PER_IO*g+`BST_CELL_OUT];
		end
	endgenerate

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			irSh_r <= `BST_IR_BYPASS;
			ir_r   <= `BST_IR_BYPASS;
		end else begin
			if (st_r == CIR)
				irSh_r <= `BST_IR_CAPTURE;
			else if (st_r == SIR)
				irSh_r <= {tdi, irSh_r[2:1]};
			if (st_r == TLR)
				ir_r <= `BST_IR_BYPASS;
			else if (st_r == UIR)
				ir_r <= irSh_r;
		end
	end

	// boundary chain, tdi enters the top cell, lowest cell exits
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			bsSh_r  <= '0;
			bsUpd_r <= '0;
			byp_r   <= 1'b0;
		end else begin
			if (st_r == CDR && bsSel)
				bsSh_r <= parIn;
			else if (st_r == SDR && bsSel)
				bsSh_r <= {tdi, bsSh_r[CN-1:1]};
			if (st_r == CDR)
				byp_r <= 1'b0;
			else if (st_r == SDR)
				byp_r <= tdi;
			if (st_r == UDR && bsSel)
				bsUpd_r <= bsSh_r;
		end
	end

	// output shifted out on falling edge; enable only while shifting
	wire tdoSel = (st_r == SIR) ? irSh_r[0] : (bsSel ? bsSh_r[0] : byp_r);
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdoNeg_r <= 1'b0;
			oeNeg_r  <= 1'b0;
		end else begin
			tdoNeg_r <= tdoSel;
			oeNeg_r  <= (st_r == SIR) || (st_r == SDR);
		end
	end
	assign tdo   = tdoNeg_r;
	assign tdoOe = oeNeg_r;

	// pin paths; drive from cells, floats, passes core
	logic [NIO-1:0] padOut_r, padOe_r, coreIn_r;
	generate
		for (g = 0; g < NIO; g++) begin : g_pad
			always_ff @(posedge tck or posedge rst) begin
				if (rst) begin
					padOut_r[g] <= 1'b0;
					padOe_r[g]  <= 1'b0;
					coreIn_r[g] <= 1'b0;
				end else begin
					padOut_r[g] <= (mode == MODE_DRIVE) ? bsUpd_r[`BST_CELLS_PER_IO*g+`BST_CELL_OUT] : coreOut[g];
					padOe_r[g]  <= (mode == MODE_DRIVE) ? bsUpd_r[`BST_CELLS_PER_IO*g+`BST_CELL_OE]
						: ((mode == MODE_HIGHZ) ? 1'b0 : coreOe[g]);
					coreIn_r[g] <= (mode == MODE_DRIVE) ? bsUpd_r[`BST_CELLS_PER_IO*g+`BST_CELL_IN] : padIn[g];
				end
			end
		end
	endgenerate
	assign padOut = padOut_r;
	assign padOe  = padOe_r;
	assign coreIn = coreIn_r;

	// Test flag from a flop, so the synchroniser never sees decode glitches
	logic testFlag_r;
	always_ff @(posedge tck or posedge rst) begin
		if (rst)
			testFlag_r <= 1'b0;
		else
			testFlag_r <= (mode != MODE_FUNC);
	end

	// Crossing of instruction and test flag into system domain
	logic [2:0] instrS1_r, instrS2_r, instrS3_r, instrQ_r;
	logic [2:0] actS_r;
	logic       testActive_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instrS1_r    <= `BST_IR_BYPASS;
			instrS2_r    <= `BST_IR_BYPASS;
			instrS3_r    <= `BST_IR_BYPASS;
			instrQ_r     <= `BST_IR_BYPASS;
			actS_r       <= 3'h0;
			testActive_r <= 1'b0;
		end else begin
			instrS1_r <= ir_r;
			instrS2_r <= instrS1_r;
			instrS3_r <= instrS2_r;
			// Accept only when two later stages agree, so a skewed word is not seen
			if (instrS2_r == instrS3_r)
				instrQ_r <= instrS3_r;
			actS_r <= {actS_r[1:0], testFlag_r};
			if (actS_r[1] == actS_r[2])
				testActive_r <= actS_r[2];
		end
	end
	assign instr      = instrQ_r;
	assign testActive = testActive_r;

	// Captured snapshots stream to the system side through the FIFO
	bst_fifo_if #(.W(CN)) capIf ();
	assign capIf.inValid  = (st_r == CDR) && bsSel;
	assign capIf.inData   = parIn;
	assign capIf.outReady = capReady;
	assign capValid       = capIf.outValid;
	assign capData        = capIf.outData;
	// A full FIFO drops the snapshot; the scan itself is never stalled
	bst_fifo #(.W(CN), .DEPTH(4)) u_fifo (
		.wClk (tck),
		.rClk (clk),
		.rst  (rst),
		.port (capIf.fifo)
	);

	// Assertions
	property p_tlr5;
		@(posedge tck) disable iff (rst) (tms5_r == 3'h5) |-> st_r == TLR;
	endproperty
	a_tlr5: assert property (p_tlr5) else $error("five tms highs did not reset");
	property p_oe;
		@(negedge tck) disable iff (rst) !(st_r == SIR || st_r == SDR) |=> !tdoOe;
	endproperty
	a_oe: assert property (p_oe) else $error("tdo driven outside shift");
	property p_irrst;
		@(posedge tck) disable iff (rst) st_r == TLR |=> ir_r == `BST_IR_BYPASS;
	endproperty
	a_irrst: assert property (p_irrst) else $error("reset left non bypass");
	property p_highz;
		@(posedge tck) disable iff (rst) isHighz && $past(isHighz) |-> padOe == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("pin driven in highz");
	property p_drive;
		@(posedge tck) disable iff (rst) (isExtest || isClamp) |=> padOut[0] == $past(bsUpd_r[`BST_CELL_OUT]);
	endproperty
	a_drive: assert property (p_drive) else $error("pin not from cell");
	property p_sample;
		@(posedge tck) disable iff (rst) isSample |=> padOut == $past(coreOut);
	endproperty
	a_sample: assert property (p_sample) else $error("sample disturbed pins");
	property p_byp;
		@(posedge tck) disable iff (rst) st_r == SDR && isBypass |=> byp_r == $past(tdi);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass bit wrong");
	property p_cap;
		@(posedge tck) disable iff (rst) st_r == CDR && bsSel |=> bsSh_r == $past(parIn);
	endproperty
	a_cap: assert property (p_cap) else $error("capture missed pins");
	property p_shift;
		@(posedge tck) disable iff (rst) st_r == SDR && bsSel |=> bsSh_r[CN-1] == $past(tdi);
	endproperty
	a_shift: assert property (p_shift) else $error("chain not fed by tdi");
	// Data out moves on the falling edge with the chain end
	property p_tdoFall;
		@(negedge tck) disable iff (rst) st_r == SDR && bsSel |=> tdo == $past(bsSh_r[0]);
	endproperty
	a_tdoFall: assert property (p_tdoFall) else $error("tdo not from chain end");
	// Bypass bit reaches data out half a clock later
	property p_bypTdo;
		@(negedge tck) disable iff (rst) st_r == SDR && !bsSel |=> tdo == $past(byp_r);
	endproperty
	a_bypTdo: assert property (p_bypTdo) else $error("tdo not from bypass");
	// Clamp holds every pin at its output cell
	property p_clamp;
		@(posedge tck) disable iff (rst) isClamp |=> padOut == $past(updOut);
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp pin not from cell");
	// Instruction takes the shifted word at update
	property p_irUpd;
		@(posedge tck) disable iff (rst) st_r == UIR |=> ir_r == $past(irSh_r);
	endproperty
	a_irUpd: assert property (p_irUpd) else $error("instruction not updated");
	// Mode select steers the controller on the rising edge
	property p_modeSel;
		@(posedge tck) disable iff (rst) st_r == RTI && tms |=> st_r == SDS;
	endproperty
	a_modeSel: assert property (p_modeSel) else $error("idle did not leave on tms");

	// Main scenarios
	c_ir:  cover property (@(posedge tck) st_r == UIR);
	c_dr:  cover property (@(posedge tck) st_r == UDR && isExtest);
	c_cap: cover property (@(posedge clk) capValid && capReady);
	c_highz: cover property (@(posedge tck) isHighz && st_r == RTI);
	c_byp:   cover property (@(posedge tck) st_r == SDR && isBypass);
endmodule

//--- bench/bst_jtag_model.sv
`timescale 1ns/1ps
// Test controller on the far side of the serial test port
module bst_jtag_model #(
	parameter int HALF = 30
) (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdoOe
);
	// A released line reads as the inverse so a stale bit never matches
	wire tdoLine = tdoOe ? tdo : ~tdo;
	// Enable as seen with the data bit, before the rising edge
	logic oeSeen;

	// Clock rests low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// test clock limit
	// One test clock cycle; data out is read just before the rising edge
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#(HALF);
		q = tdoLine;
		oeSeen = tdoOe;
		tck = 1'b1;
		#(HALF);
		tck = 1'b0;
	endtask

	// From idle through capture, shift, update and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout,
			output logic oeOk);
		logic q;
		dout = '0;
		oeOk = 1'b1;
		tick(1'b1, 1'b0, q);
		if (ir) begin
			tick(1'b1, 1'b0, q);
		end
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int k = 0; k < n; k++) begin
			tick(k == n - 1, din[k], q);
			dout[k] = q;
			oeOk &= oeSeen;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		// Extra edge covers the one-cycle pin lag
		tick(1'b0, 1'b0, q);
		oeOk &= !oeSeen;
	endtask

	// Five high mode-select edges, then idle; second idle edge lets pins follow
	task automatic tlr();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
endmodule

//--- bench/boundary_scan_tap_tb.sv
`timescale 1ns/1ps
module boundary_scan_tap_tb;
	localparam int NIO = 4;
	logic             clk, rst, tck, tms, tdi, tdo, tdoOe, capValid, capReady, testActive, oeOk;
	logic [NIO-1:0]   coreOut, coreOe, coreIn, padIn, padOut, padOe;
	logic [2:0]       instr;
	logic [3*NIO-1:0] capData;
	logic [31:0]      so;
	int               failures = 0;
	int               compares = 0;
	int               cycles = 0;

	bst_tap #(.NIO(NIO)) bst_tap_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdoOe(tdoOe), .coreOut(coreOut), .coreOe(coreOe), .coreIn(coreIn), .padIn(padIn),
		.padOut(padOut), .padOe(padOe), .instr(instr), .testActive(testActive), .capValid(capValid),
		.capData(capData), .capReady(capReady));
	bst_jtag_model bst_jtag_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

	// System clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, well above the longest run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			end_sim();
		end
	end

	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	// Expected chain image: per pin input, output, enable from bit 0 up
	function automatic logic [3*NIO-1:0] cells(input logic [NIO-1:0] i, o, e);
		for (int k = 0; k < NIO; k++) cells[3*k+:3] = {e[k], o[k], i[k]};
	endfunction

	task automatic loadIr(input logic [2:0] code);
		int n;
		bst_jtag_model_i.scan(1'b1, 3, {29'h0, code}, so, oeOk);
		check(so[2:0] === 3'h1, "ir capture");
		check(oeOk === 1'b1, "tdo enable");
		n = 0;
		while (instr !== code && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(instr === code, "instr");
		// Room for the test flag crossing
		repeat (6) @(posedge clk);
	endtask

	task automatic t_reset();
		check(instr === 3'h7, "reset instr");
		check(tdoOe === 1'b0, "idle tdo");
		$display("test reset done");
	endtask

	task automatic t_sample();
		int n;
		@(posedge clk);
		padIn <= 4'h9;
		coreOut <= 4'h5;
		coreOe <= 4'h3;
		loadIr(3'h1);
		bst_jtag_model_i.scan(1'b0, 12, 32'h8b4, so, oeOk);
		check(so[11:0] === cells(4'h9, 4'h5, 4'h3), "snapshot");
		check(padOut === 4'h5 && padOe === 4'h3 && coreIn === 4'h9, "pass");
		n = 0;
		while (capValid !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(capValid === 1'b1 && capData === cells(4'h9, 4'h5, 4'h3), "stream");
		@(posedge clk);
		capReady <= 1'b1;
		$display("test sample done");
	endtask

	task automatic t_bypass();
		logic [2:0] codes [4] = '{3'h7, 3'h2, 3'h3, 3'h4};
		foreach (codes[c]) begin
			loadIr(codes[c]);
			bst_jtag_model_i.scan(1'b0, 4, 32'hb, so, oeOk);
			check(so[3:0] === 4'h6, "bypass bit");
			check(padOut === 4'h5 && testActive === 1'b0, "bypass pins");
		end
		$display("test bypass done");
	endtask

	task automatic t_extest();
		loadIr(3'h0);
		check(padOut === 4'h6 && padOe === 4'hb && testActive === 1'b1, "drive");
		bst_jtag_model_i.scan(1'b0, 12, 32'hd26, so, oeOk);
		check({so[9], so[6], so[3], so[0]} === 4'h9, "pin capture");
		check(padOut === 4'h9 && padOe === 4'hf, "update");
		$display("test extest done");
	endtask

	task automatic t_highz_clamp();
		loadIr(3'h5);
		check(padOe === 4'h0 && testActive === 1'b1, "float");
		loadIr(3'h6);
		check(padOut === 4'h9, "clamp");
		$display("test highz clamp done");
	endtask

	task automatic t_tlr();
		logic q;
		int n;
		bst_jtag_model_i.tick(1'b1, 1'b0, q);
		bst_jtag_model_i.tick(1'b0, 1'b0, q);
		bst_jtag_model_i.tick(1'b0, 1'b0, q);
		bst_jtag_model_i.tlr();
		n = 0;
		while (instr !== 3'h7 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(instr === 3'h7 && tdoOe === 1'b0, "tap reset");
		check(padOut === 4'h5, "pins restored");
		$display("test tlr done");
	endtask

	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		capReady = 1'b0;
		coreOut = '0;
		coreOe = '0;
		padIn = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		// Walk the port from reset to idle before any scan
		bst_jtag_model_i.tlr();
		t_sample();
		t_bypass();
		t_extest();
		t_highz_clamp();
		t_tlr();
		end_sim();
	end
endmodule
